// >>> rtl/adcdc_consts.vh
`ifndef ADCDC_CONSTS_VH
`define ADCDC_CONSTS_VH
// result width in bits
`define ADCDC_DATA_W 18
// conversion time in ns and its cycle count at 50 MHz
`define ADCDC_CONV_NS 2000
`define ADCDC_CLK_MHZ 50
`define ADCDC_CONV_CYC ((`ADCDC_CONV_NS * `ADCDC_CLK_MHZ + 999) / 1000)
// states
`define ADCDC_ST_IDLE 2'h0
`define ADCDC_ST_CONV 2'h1
`define ADCDC_ST_SHIFT 2'h2
`define ADCDC_ST_CSM 2'h3
`endif

// >>> rtl/adcdc_readout.v
// Function
// - chain input low at start selects chain mode
// - chain input high at start selects select mode
// - both inputs low drive chain output low
// - start edge with input low starts conversion
// - conversion runs on internal clock only
// - no indicator: MSB shown at conversion end
// - each falling edge shifts input in, next out, bar the first with indicator
// - indicator: output driven high at conversion end
// - upstream indicator bits are not passed on
// - output stays valid across both clock edges
`timescale 1ns/1ps
`default_nettype none
`include "adcdc_consts.vh"
module adcdc_readout #(
    parameter DATA_W = `ADCDC_DATA_W,
    parameter CONV_CYC = `ADCDC_CONV_CYC
) (
    // clock and reset
    input wire CLK_I,
    input wire RESETN_I,
    // link pins
    input wire CONVERSION_START_I,
    input wire SERIAL_CLOCK_I,
    input wire SERIAL_CHAIN_INPUT_I,
    output wire SERIAL_CHAIN_OUTPUT_O,
    output wire SERIAL_CHAIN_OUTPUT_OE_O,
    // converter core
    input wire [DATA_W-1:0] RESULT_I,
    output wire SAMPLE_O,
    // status
    output wire CHAIN_MODE_O,
    output wire BUSY_MODE_O,
    output wire CONV_BUSY_O
);
// synchronised pins
wire cnv_s;
wire sck_s;
wire sdi_s;

adcdc_sync u_sync_cnv (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .d_i(CONVERSION_START_I),
    .q_o(cnv_s)
);
adcdc_sync u_sync_sck (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .d_i(SERIAL_CLOCK_I),
    .q_o(sck_s)
);
adcdc_sync u_sync_sdi (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .d_i(SERIAL_CHAIN_INPUT_I),
    .q_o(sdi_s)
);

// phase codes
localparam [1:0] ST_IDLE = `ADCDC_ST_IDLE;
localparam [1:0] ST_CONV = `ADCDC_ST_CONV;
localparam [1:0] ST_SHIFT = `ADCDC_ST_SHIFT;
localparam [1:0] ST_CSM = `ADCDC_ST_CSM;

// phase and mode
reg [1:0] state_ff;
reg [1:0] nxt_state;
reg chain_ff;
reg nxt_chain;
reg busy_mode_ff;
reg nxt_busy_mode;
reg sample_ff;
reg nxt_sample;
// edge detect delays
reg cnv_d_ff;
reg sck_d_ff;
// conversion timer
reg [15:0] cnt_ff;
reg [15:0] nxt_cnt;
// result word and pending indicator bit
reg [DATA_W-1:0] sh_ff;
reg [DATA_W-1:0] nxt_sh;
reg ind_ff;
reg nxt_ind;
// pin driver
reg sdo_ff;
reg nxt_sdo;
reg sdo_oe_ff;
reg nxt_sdo_oe;

// high for one cycle when a level goes from low to high
function edge_up;
    input cur;
    input prev;
    begin
        edge_up = cur & ~prev;
    end
endfunction

wire cnv_rise = edge_up(cnv_s, cnv_d_ff);
// a fall of the serial clock is a rise of its inverse
wire sck_fall = edge_up(sck_d_ff, sck_s);
wire conv_done = (cnt_ff == 16'h0001);

// edge detect delays
always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
        cnv_d_ff <= 1'b0;
        sck_d_ff <= 1'b0;
    end else begin
        cnv_d_ff <= cnv_s;
        sck_d_ff <= sck_s;
    end
end

// mode capture at the start edge and phase sequencing
always @* begin
    nxt_state = state_ff;
    nxt_chain = chain_ff;
    nxt_busy_mode = busy_mode_ff;
    nxt_sample = 1'b0;
    case (state_ff)
        ST_IDLE: begin
            if (cnv_rise) begin
                nxt_sample = 1'b1;
                nxt_busy_mode = sck_s;
                if (!sdi_s) begin
                    nxt_chain = 1'b1;
                    nxt_state = ST_CONV;
                end else begin
                    nxt_chain = 1'b0;
                    nxt_state = ST_CSM;
                end
            end
        end
        ST_CONV: begin
            // only the timer ends this phase
            if (conv_done)
                nxt_state = ST_SHIFT;
        end
        ST_SHIFT: begin
            // start going low ends the readout
            if (!cnv_s)
                nxt_state = ST_IDLE;
        end
        ST_CSM: begin
            // no readout in select mode; start going low ends this phase
            if (!cnv_s)
                nxt_state = ST_IDLE;
        end
        default: nxt_state = ST_IDLE;
    endcase
end

// conversion timer, loaded at the start edge, blind to the serial clock
always @* begin
    nxt_cnt = cnt_ff;
    if (state_ff == ST_IDLE && cnv_rise)
        nxt_cnt = CONV_CYC[15:0];
    else if (state_ff == ST_CONV)
        nxt_cnt = cnt_ff - 16'h0001;
end

// result and indicator loaded at conversion end, shifted on falls
always @* begin
    nxt_sh = sh_ff;
    nxt_ind = ind_ff;
    if (state_ff == ST_CONV && conv_done) begin
        nxt_sh = RESULT_I;
        nxt_ind = busy_mode_ff;
    end else if (state_ff == ST_SHIFT && sck_fall) begin
        if (ind_ff) begin
            // first fall only drops our indicator; the upstream
            // indicator on the chain input now is never taken in
            nxt_ind = 1'b0;
        end else begin
            nxt_sh = {sh_ff[DATA_W-2:0], sdi_s};
        end
    end
end

// pin driver: data in readout, low while both inputs low, else off
always @* begin
    nxt_sdo = 1'b0;
    nxt_sdo_oe = 1'b0;
    if (state_ff == ST_SHIFT) begin
        // changes only a few cycles after a fall, so it stands
        // across the following rise and up to the next fall
        nxt_sdo = ind_ff ? 1'b1 : sh_ff[DATA_W-1];
        nxt_sdo_oe = 1'b1;
    end else if (!cnv_s && !sdi_s) begin
        nxt_sdo_oe = 1'b1;
    end
end

// phase and mode registers
always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
        state_ff <= ST_IDLE;
        chain_ff <= 1'b0;
        busy_mode_ff <= 1'b0;
        sample_ff <= 1'b0;
    end else begin
        state_ff <= nxt_state;
        chain_ff <= nxt_chain;
        busy_mode_ff <= nxt_busy_mode;
        sample_ff <= nxt_sample;
    end
end

// timer and shift registers
always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
        cnt_ff <= 16'h0000;
        sh_ff <= {DATA_W{1'b0}};
        ind_ff <= 1'b0;
    end else begin
        cnt_ff <= nxt_cnt;
        sh_ff <= nxt_sh;
        ind_ff <= nxt_ind;
    end
end

// pin registers
always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
        sdo_ff <= 1'b0;
        sdo_oe_ff <= 1'b0;
    end else begin
        sdo_ff <= nxt_sdo;
        sdo_oe_ff <= nxt_sdo_oe;
    end
end

assign SERIAL_CHAIN_OUTPUT_O = sdo_ff;
assign SERIAL_CHAIN_OUTPUT_OE_O = sdo_oe_ff;
assign SAMPLE_O = sample_ff;
assign CHAIN_MODE_O = chain_ff;
assign BUSY_MODE_O = busy_mode_ff;
assign CONV_BUSY_O = (state_ff == ST_CONV);
endmodule // adcdc_readout
`default_nettype wire

// >>> rtl/adcdc_sync.v
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a pin input
module adcdc_sync (
    // clock and reset
    input wire clk_i,
    input wire resetn_i,
    // pin side
    input wire d_i,
    // clock side
    output wire q_o
);
reg s1_ff;
reg s2_ff;

// first stage feeds only the second
always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
    end else begin
        s1_ff <= d_i;
        s2_ff <= s1_ff;
    end
end

assign q_o = s2_ff;
endmodule // adcdc_sync
`default_nettype wire

// >>> tb/adcdc_host.sv
`timescale 1ns/1ps
`default_nettype none
module adcdc_host (
    // clock and chain end
    input wire logic clk,
    input wire logic serial_chain_output,
    // shared host lines and upstream converter output
    output logic conversion_start,
    output logic sck,
    output logic serial_chain_input
);
    logic [18:0] u;
    // idle lines low
    initial {conversion_start, sck, serial_chain_input} = 3'h0;
    // start with chosen clock level and chain input level
    task start(input logic b, input logic s);
        @(negedge clk);
        sck = b;
        serial_chain_input = s;
        @(negedge clk);
        conversion_start = 1;
        repeat (16) @(negedge clk);
    endtask
    // n bits, sampled at each rise and before each fall
    task read(input logic [18:0] up, input int n,
              output logic [36:0] q, output logic [36:0] f);
        q = 0;
        f = 0;
        u = up;
        serial_chain_input = u[18];
        repeat (n) begin
            sck = 1;
            q = {q[35:0], serial_chain_output};
            repeat (4) @(negedge clk);
            f = {f[35:0], serial_chain_output};
            sck = 0;
            repeat (2) @(negedge clk);
            u = u << 1;
            serial_chain_input = u[18];
            repeat (2) @(negedge clk);
        end
        conversion_start = 0;
        serial_chain_input = 0;
        @(negedge clk);
    endtask
endmodule // adcdc_host
`default_nettype wire

// >>> tb/adcdc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adcdc_props #(parameter DATA_W = 18) (
    // watched ports
    input wire logic CLK_I, RESETN_I, CONVERSION_START_I,
    input wire logic SERIAL_CHAIN_INPUT_I, SERIAL_CHAIN_OUTPUT_O,
    input wire logic SERIAL_CHAIN_OUTPUT_OE_O, SAMPLE_O, CHAIN_MODE_O,
    input wire logic BUSY_MODE_O, CONV_BUSY_O,
    input wire logic [DATA_W-1:0] RESULT_I
);
    // short names for the chain output enable and busy
    wire e = SERIAL_CHAIN_OUTPUT_OE_O;
    wire c = CONV_BUSY_O;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    property p_sp; SAMPLE_O |=> !SAMPLE_O; endproperty
    a_sp: assert property (p_sp) else $error("sample");
    property p_st; SAMPLE_O && CHAIN_MODE_O |-> ##[0:2] c; endproperty
    a_st: assert property (p_st) else $error("start");
    property p_cs; SAMPLE_O && !CHAIN_MODE_O |-> !c ##1 !c; endproperty
    a_cs: assert property (p_cs) else $error("select");
    property p_cv; $rose(c) |-> c [*4] ##1 !c; endproperty
    a_cv: assert property (p_cv) else $error("conv");
    property p_lo; (!CONVERSION_START_I && !SERIAL_CHAIN_INPUT_I) [*6]
        |=> e && !SERIAL_CHAIN_OUTPUT_O; endproperty
    a_lo: assert property (p_lo) else $error("idle");
    property p_bz; $fell(c) && CHAIN_MODE_O && BUSY_MODE_O
        |-> ##2 (e && SERIAL_CHAIN_OUTPUT_O); endproperty
    a_bz: assert property (p_bz) else $error("ind");
    property p_ms; $fell(c) && CHAIN_MODE_O && !BUSY_MODE_O
        |-> ##2 (e && SERIAL_CHAIN_OUTPUT_O == RESULT_I[DATA_W-1]);
    endproperty
    a_ms: assert property (p_ms) else $error("msb");
    property p_bm; $rose(c) |=> $stable(BUSY_MODE_O) [*3]; endproperty
    a_bm: assert property (p_bm) else $error("bmode");
    property p_cm; $rose(c) |=> $stable(CHAIN_MODE_O) [*3]; endproperty
    a_cm: assert property (p_cm) else $error("cmode");
endmodule // adcdc_props
bind adcdc_readout adcdc_props #(.DATA_W(DATA_W)) u_chk (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I),
    .CONVERSION_START_I(CONVERSION_START_I),
    .SERIAL_CHAIN_INPUT_I(SERIAL_CHAIN_INPUT_I),
    .SERIAL_CHAIN_OUTPUT_O(SERIAL_CHAIN_OUTPUT_O),
    .SERIAL_CHAIN_OUTPUT_OE_O(SERIAL_CHAIN_OUTPUT_OE_O),
    .SAMPLE_O(SAMPLE_O), .CHAIN_MODE_O(CHAIN_MODE_O),
    .BUSY_MODE_O(BUSY_MODE_O), .CONV_BUSY_O(CONV_BUSY_O),
    .RESULT_I(RESULT_I)
);
`default_nettype wire

// >>> tb/test_adc_daisy_chain_readout.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_daisy_chain_readout;
    localparam logic [17:0] UP_W = 18'h0C3F9;
    logic clk = 0;
    logic rst_n = 0;
    logic [17:0] res = 18'h2A5C3;
    wire conversion_start, sck, serial_chain_input, serial_chain_output, oe, cm, bm;
    int bad_count = 0;
    int n_compared = 0;
    // converter and host with upstream converter
    adcdc_readout #(.CONV_CYC(4)) uut (.CLK_I(clk), .RESETN_I(rst_n),
        .CONVERSION_START_I(conversion_start), .SERIAL_CLOCK_I(sck),
        .SERIAL_CHAIN_INPUT_I(serial_chain_input), .SERIAL_CHAIN_OUTPUT_O(serial_chain_output),
        .SERIAL_CHAIN_OUTPUT_OE_O(oe), .RESULT_I(res), .SAMPLE_O(),
        .CHAIN_MODE_O(cm), .BUSY_MODE_O(bm), .CONV_BUSY_O());
    adcdc_host h (.clk(clk), .serial_chain_output(serial_chain_output), .conversion_start(conversion_start), .sck(sck), .serial_chain_input(serial_chain_input));
    always #10 clk = ~clk;
    task chk(input logic [36:0] s, input logic [36:0] e);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %0t %h %h", $time, s, e);
        end
    endtask
    task close_out;
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // idle chain drives its output low
    task t_idle;
        repeat (8) @(negedge clk);
        chk({oe, serial_chain_output}, 2'h2);
    endtask
    // chained readout with or without indicator
    task t_read(input logic b);
        logic [36:0] q, f;
        res = b ? 18'h35A0F : 18'h2A5C3;
        h.start(b, 1'b0);
        chk(cm, 1'b1);
        chk(bm, b);
        h.read(b ? {1'b1, UP_W} : {UP_W, 1'b0}, 36 + b, q, f);
        chk(q, {b, res, UP_W});
        chk(f, q);
        t_idle;
    endtask
    // chain input high at start picks the other mode
    task t_sel;
        logic [36:0] q, f;
        h.start(1'b0, 1'b1);
        chk(cm, 1'b0);
        h.read(19'h0, 0, q, f);
        t_idle;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1;
        t_idle;
        t_read(1'b0);
        t_read(1'b1);
        t_sel;
        close_out;
    end
    // watchdog
    initial begin
        #100000;
        bad_count++;
        close_out;
    end
endmodule // test_adc_daisy_chain_readout
`default_nettype wire
